// *** src/pio_pkg.sv ***
/*
 Package for the shared parallel I/O ports: register map, implemented-bit masks,
 reset values. Assumes a 32-bit APB master and five 16-bit ports.
*/
package pio_pkg;
	localparam int NUM_PORTS = 5;
	localparam int PORT_W = 16;
	localparam int REG_PER_PORT = 8;
	localparam int ADDR_W = 12;
	// Register index within a port block (word index)
	localparam logic [2:0] IDX_DIRECTION = 3'h0;
	localparam logic [2:0] IDX_PIN_LEVEL = 3'h1;
	localparam logic [2:0] IDX_OUTPUT_LATCH = 3'h2;
	localparam logic [2:0] IDX_OPEN_DRAIN = 3'h3;
	localparam logic [2:0] IDX_CHANGE_IRQ_ENABLE = 3'h4;
	localparam logic [2:0] IDX_PULLUP_ENABLE = 3'h5;
	localparam logic [2:0] IDX_PULLDOWN_ENABLE = 3'h6;
	localparam logic [2:0] IDX_ANALOG_SELECT = 3'h7;
	// Byte address fields: [4:2] register, [7:5] port
	localparam int REG_LSB = 2;
	localparam int PORT_LSB = 5;
	// Interrupt block
	localparam logic [ADDR_W-1:0] ADDR_CHANGE_STATUS = 12'h100;
	localparam logic [ADDR_W-1:0] ADDR_CHANGE_MASK = 12'h104;
	localparam logic [ADDR_W-1:0] ADDR_CHANGE_STATUS_PORT = 12'h108;
	localparam logic [ADDR_W-1:0] ADDR_CHANGE_MASK_PORT = 12'h10C;
	localparam int STATUS_W = NUM_PORTS;
	// Implemented pins (largest variant)
	localparam logic [NUM_PORTS*PORT_W-1:0] PIN_IMPL = {
		16'hFFFF, 16'hFFFF, 16'hF7FF, 16'hFBFF, 16'h001F};
	// Implemented analog select bits
	localparam logic [NUM_PORTS*PORT_W-1:0] ANALOG_IMPL = {
		16'h0000, 16'h21A4, 16'h1676, 16'h02EF, 16'h0007};
	localparam logic [PORT_W-1:0] DIRECTION_RESET = 16'hFFFF;
	localparam logic [PORT_W-1:0] ANALOG_RESET = 16'hFFFF;
	localparam logic [PORT_W-1:0] ZERO_WORD = 16'h0000;
	localparam logic [31:0] ZERO_DATA = 32'h0000_0000;
endpackage

// *** src/shared_parallel_io_ports.sv ***
/*
 Five shared 16-bit parallel I/O ports with APB register access and a
 change-notification interrupt. Assumes pin inputs synchronous to ref_clk_in,
 and that peripherals flag their own enable and active drive per pin.
*/
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - An enabled peripheral that drives a pin owns its output; the port driver is off, pin stays readable.
// - An enabled peripheral that does not drive a pin leaves that pin to the port logic.
// - A port's own output never feeds the input of a peripheral on the same pin.
// - A direction bit of one makes the pin an input, zero an output.
// - Every reset sets all implemented direction bits so every port-owned pin is an input.
// - The output latch register reads back the latch and writes store into it.
// - The pin level register reads the sampled pins and writes go to the output latch.
// - Unimplemented port bits are disabled and read zero in latch, direction and pin level.
// - A pin shared only with input functions behaves as a dedicated port pin.
// - Each port has eight registers: direction, level, latch, open drain, irq enable, pull-up, pull-down, analog.
// - An open-drain bit set makes a port-owned pin only sink current and never drive high.
// - All unimplemented register bit positions read as zero, analog select included.
// - Implemented analog select bits reset to ones; unimplemented bits reset to zero.
// - Pins set as analog read zero in the pin level register.
// - A change on a pin with its change enable set sets its change flag; the interrupt also needs its pin and port mask bits.
// - Weak pull-up and pull-down are enabled independently per pin.
module shared_parallel_io_ports
	import pio_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Pins
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_in,
	output logic [NUM_PORTS*PORT_W-1:0] pin_out,
	output logic [NUM_PORTS*PORT_W-1:0] pin_oe_n_out,
	output logic [NUM_PORTS*PORT_W-1:0] weak_pullup_enable_out,
	output logic [NUM_PORTS*PORT_W-1:0] weak_pulldown_enable_out,
	output logic [NUM_PORTS*PORT_W-1:0] analog_select_out,
	// Peripherals sharing the pins
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_enable_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_drive_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_out_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_od_in,
	output logic [NUM_PORTS*PORT_W-1:0] periph_pin_level_out,
	// Interrupt
	output logic change_irq_out
);
	localparam int N = NUM_PORTS * PORT_W;

	logic [N-1:0] pin_direction_bits_q;
	logic [N-1:0] output_latch_bits_q;
	logic [N-1:0] open_drain_select_q;
	logic [N-1:0] change_irq_enable_q;
	logic [N-1:0] weak_pullup_enable_q;
	logic [N-1:0] weak_pulldown_enable_q;
	logic [N-1:0] analog_select_q;
	logic [N-1:0] sample_q;
	logic [N-1:0] prev_sample_q;
	logic [N-1:0] change_flag_q;
	logic [STATUS_W-1:0] port_mask_q;
	logic [N-1:0] pin_mask_q;

	logic setup_phase;
	logic access_phase;
	logic wr_en;
	logic rd_en;
	logic [2:0] reg_idx;
	logic [2:0] port_idx;
	logic port_hit;
	logic [N-1:0] wr_field;
	logic [N-1:0] wr_value;
	logic [N-1:0] change_event;
	logic [STATUS_W-1:0] port_status;
	logic [31:0] rd_data_d;
	logic rd_err_d;
	logic [N-1:0] port_owns;
	logic [N-1:0] drive_val;
	logic [N-1:0] drive_oe_n;
	logic [N-1:0] od_sel;
	logic [N-1:0] status_clear;

	function automatic logic [PORT_W-1:0] slice16(input logic [N-1:0] v, input logic [2:0] p);
		slice16 = v[p*PORT_W +: PORT_W];
	endfunction

	function automatic logic [31:0] widen(input logic [PORT_W-1:0] v);
		widen = {ZERO_WORD, v};
	endfunction

	// Bus decode
	assign setup_phase = psel_in && !penable_in;
	assign access_phase = psel_in && penable_in && clk_en_in;
	assign wr_en = access_phase && pwrite_in;
	assign rd_en = access_phase && !pwrite_in;
	assign reg_idx = paddr_in[REG_LSB +: 3];
	assign port_idx = paddr_in[PORT_LSB +: 3];
	assign port_hit = (paddr_in[ADDR_W-1:PORT_LSB+3] == '0) && (port_idx < 3'(NUM_PORTS))
		&& (paddr_in[1:0] == 2'h0);

	always_comb begin
		wr_field = '0;
		wr_value = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (port_hit && port_idx == 3'(p)) begin
				wr_field[p*PORT_W +: PORT_W] = '1;
			end
			wr_value[p*PORT_W +: PORT_W] = pwdata_in[PORT_W-1:0];
		end
	end

	// Direction register
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			pin_direction_bits_q <= {NUM_PORTS{DIRECTION_RESET}} & PIN_IMPL;
		end else if (wr_en && reg_idx == IDX_DIRECTION) begin
			pin_direction_bits_q <= ((pin_direction_bits_q & ~wr_field) | (wr_value & wr_field))
				& PIN_IMPL;
		end
	end

	// Output latch, written through latch or pin level register
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			output_latch_bits_q <= '0;
		end else if (wr_en && (reg_idx == IDX_OUTPUT_LATCH || reg_idx == IDX_PIN_LEVEL)) begin
			output_latch_bits_q <= ((output_latch_bits_q & ~wr_field) | (wr_value & wr_field))
				& PIN_IMPL;
		end
	end

	// Pin control registers
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			open_drain_select_q <= '0;
			change_irq_enable_q <= '0;
			weak_pullup_enable_q <= '0;
			weak_pulldown_enable_q <= '0;
			analog_select_q <= {NUM_PORTS{ANALOG_RESET}} & ANALOG_IMPL;
		end else if (wr_en) begin
			unique case (reg_idx)
				IDX_OPEN_DRAIN: begin
					open_drain_select_q <= ((open_drain_select_q & ~wr_field)
						| (wr_value & wr_field)) & PIN_IMPL;
				end
				IDX_CHANGE_IRQ_ENABLE: begin
					change_irq_enable_q <= ((change_irq_enable_q & ~wr_field)
						| (wr_value & wr_field)) & PIN_IMPL;
				end
				IDX_PULLUP_ENABLE: begin
					weak_pullup_enable_q <= ((weak_pullup_enable_q & ~wr_field)
						| (wr_value & wr_field)) & PIN_IMPL;
				end
				IDX_PULLDOWN_ENABLE: begin
					weak_pulldown_enable_q <= ((weak_pulldown_enable_q & ~wr_field)
						| (wr_value & wr_field)) & PIN_IMPL;
				end
				IDX_ANALOG_SELECT: begin
					analog_select_q <= ((analog_select_q & ~wr_field)
						| (wr_value & wr_field)) & ANALOG_IMPL;
				end
				default: begin
				end
			endcase
		end
	end

	// Pin sampling and change detection
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			sample_q <= '0;
			prev_sample_q <= '0;
		end else if (clk_en_in) begin
			sample_q <= pin_in & PIN_IMPL & ~analog_select_q;
			prev_sample_q <= sample_q;
		end
	end

	assign change_event = (sample_q ^ prev_sample_q) & change_irq_enable_q;

	// Sticky change flags, cleared by reading the status register; set wins
	always_comb begin
		status_clear = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (rd_en && paddr_in == ADDR_CHANGE_STATUS) begin
				status_clear[p*PORT_W +: PORT_W] = '1;
			end
			if (rd_en && paddr_in == ADDR_CHANGE_STATUS_PORT + 12'(p * 16)) begin
				status_clear[p*PORT_W +: PORT_W] = '1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			change_flag_q <= '0;
		end else if (clk_en_in) begin
			change_flag_q <= (change_flag_q & ~status_clear) | change_event;
		end
	end

	// Masks: per-port summary mask and per-pin mask
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			port_mask_q <= '0;
			pin_mask_q <= '0;
		end else if (wr_en) begin
			if (paddr_in == ADDR_CHANGE_MASK) begin
				port_mask_q <= pwdata_in[STATUS_W-1:0];
			end
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (paddr_in == ADDR_CHANGE_MASK_PORT + 12'(p * 16)) begin
					pin_mask_q[p*PORT_W +: PORT_W] <= pwdata_in[PORT_W-1:0]
						& PIN_IMPL[p*PORT_W +: PORT_W];
				end
			end
		end
	end

	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			port_status[p] = |(change_flag_q[p*PORT_W +: PORT_W] & pin_mask_q[p*PORT_W +: PORT_W]);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			change_irq_out <= 1'b0;
		end else if (clk_en_in) begin
			change_irq_out <= |(port_status & port_mask_q);
		end
	end

	// Read mux
	always_comb begin
		rd_data_d = ZERO_DATA;
		rd_err_d = 1'b0;
		if (port_hit) begin
			unique case (reg_idx)
				IDX_DIRECTION: rd_data_d = widen(slice16(pin_direction_bits_q, port_idx));
				IDX_PIN_LEVEL: rd_data_d = widen(slice16(sample_q, port_idx));
				IDX_OUTPUT_LATCH: rd_data_d = widen(slice16(output_latch_bits_q, port_idx));
				IDX_OPEN_DRAIN: rd_data_d = widen(slice16(open_drain_select_q, port_idx));
				IDX_CHANGE_IRQ_ENABLE: rd_data_d = widen(slice16(change_irq_enable_q, port_idx));
				IDX_PULLUP_ENABLE: rd_data_d = widen(slice16(weak_pullup_enable_q, port_idx));
				IDX_PULLDOWN_ENABLE: rd_data_d = widen(slice16(weak_pulldown_enable_q, port_idx));
				IDX_ANALOG_SELECT: rd_data_d = widen(slice16(analog_select_q, port_idx));
			endcase
		end else if (paddr_in == ADDR_CHANGE_STATUS) begin
			rd_data_d = {{(32-STATUS_W){1'b0}}, port_status};
		end else if (paddr_in == ADDR_CHANGE_MASK) begin
			rd_data_d = {{(32-STATUS_W){1'b0}}, port_mask_q};
		end else begin
			rd_err_d = 1'b1;
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (paddr_in == ADDR_CHANGE_STATUS_PORT + 12'(p * 16)) begin
					rd_data_d = widen(slice16(change_flag_q, 3'(p)));
					rd_err_d = 1'b0;
				end
				if (paddr_in == ADDR_CHANGE_MASK_PORT + 12'(p * 16)) begin
					rd_data_d = widen(slice16(pin_mask_q, 3'(p)));
					rd_err_d = 1'b0;
				end
			end
		end
	end

	// APB answer: no wait state, ready set at the setup cycle's edge, so high in the first access cycle
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			prdata_out <= ZERO_DATA;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else if (clk_en_in) begin
			pready_out <= setup_phase;
			pslverr_out <= setup_phase && rd_err_d;
			if (setup_phase && !pwrite_in) begin
				prdata_out <= rd_data_d;
			end
		end
	end

	// Output ownership multiplexers
	always_comb begin
		port_owns = ~(periph_enable_in & periph_drive_in);
		drive_val = (port_owns & output_latch_bits_q) | (~port_owns & periph_out_in);
		od_sel = (port_owns & open_drain_select_q) | (~port_owns & periph_od_in);
		// Port drives only when direction is output
		drive_oe_n = (port_owns & pin_direction_bits_q) | (~port_owns & 1'b0 & {N{1'b0}});
		drive_oe_n = drive_oe_n | (od_sel & drive_val) | ~PIN_IMPL;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			pin_out <= '0;
			pin_oe_n_out <= '1;
			weak_pullup_enable_out <= '0;
			weak_pulldown_enable_out <= '0;
			analog_select_out <= '0;
			periph_pin_level_out <= '0;
		end else if (clk_en_in) begin
			pin_out <= drive_val & ~od_sel;
			pin_oe_n_out <= drive_oe_n;
			weak_pullup_enable_out <= weak_pullup_enable_q;
			weak_pulldown_enable_out <= weak_pulldown_enable_q;
			analog_select_out <= analog_select_q;
			// Peripheral sees the pin, but a port-driven pin is cut off
			periph_pin_level_out <= pin_in & ~(port_owns & ~pin_direction_bits_q);
		end
	end
endmodule

// *** dv/pio_pad_model.sv ***
/*
 Pad model for the parallel I/O pins.
 Assumes pin_oe_n low while the block drives.
*/
`timescale 1ns/1ns
module pio_pad_model
	import pio_pkg::*;
(
	// Pads
	input wire logic [NUM_PORTS*PORT_W-1:0] drv_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] oe_n_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] ext_in,
	output logic [NUM_PORTS*PORT_W-1:0] pad_out
);
	// Released pads follow the outside level
	assign pad_out = (~oe_n_in & drv_in) | (oe_n_in & ext_in);
endmodule

// *** dv/shared_parallel_io_ports_chk.sv ***
/*
 Port checker for the parallel I/O block.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module shared_parallel_io_ports_chk
	import pio_pkg::*;
(
	// Watched ports
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_out,
	input wire logic [NUM_PORTS*PORT_W-1:0] pin_oe_n_out,
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_enable_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_drive_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_out_in,
	input wire logic [NUM_PORTS*PORT_W-1:0] periph_pin_level_out,
	input wire logic change_irq_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	logic [NUM_PORTS*PORT_W-1:0] own;
	assign own = periph_enable_in & periph_drive_in;
	a_ready_setup: assert property (psel_in && !penable_in && clk_en_in |=> pready_out)
		else $error("no pready after setup");
	a_ready_cause: assert property (pready_out |-> $past(psel_in && !penable_in))
		else $error("pready without setup");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready too long");
	a_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("pslverr without pready");
	a_reset_input: assert property ($rose(reset_n_in) |-> &pin_oe_n_out && !change_irq_out)
		else $error("pins not inputs after reset");
	a_periph_owns: assert property ($past(reset_n_in) && $past(clk_en_in) |->
		(((pin_out ^ $past(periph_out_in)) | pin_oe_n_out) & $past(own) & PIN_IMPL) == '0)
		else $error("peripheral lost its pin");
	a_no_loop: assert property ($past(reset_n_in) |-> (periph_pin_level_out & ~pin_oe_n_out
		& ~$past(pin_oe_n_out) & ~own & ~$past(own)) == '0)
		else $error("port output loops into peripheral");
	a_irq_clear: assert property ($fell(change_irq_out) |-> $past(pready_out) || $past(pready_out, 2))
		else $error("irq dropped without access");
endmodule
bind shared_parallel_io_ports shared_parallel_io_ports_chk u_chk (.*);

// *** dv/shared_parallel_io_ports_tb_top.sv ***
/*
 Testbench for the parallel I/O block: APB master, pads, peripherals.
 Assumes the pad model and the bound checker.
*/
`timescale 1ns/1ns
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t %s", $time, m); end end
module shared_parallel_io_ports_tb_top
	import pio_pkg::*;
;
	localparam int W = NUM_PORTS*PORT_W;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic [31:0] prd, rdata;
	logic rdy, err, rerr, irq;
	logic [W-1:0] ext = '0, pen_b = '0, pdrv = '0, pout = '0;
	logic [W-1:0] pad, pout_o, oe_n, pu, pd, an, plev;
	logic [31:0] lfsr = 32'h5DE6;
	logic [31:0] q;
	logic [15:0] l, t, o, en, dv, v, m;
	int p;
	int fail_count = 0;
	int total_checks = 0;
	always #10 clk = ~clk;
	shared_parallel_io_ports u_dut (.ref_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata),
		.prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .pin_in(pad), .pin_out(pout_o),
		.pin_oe_n_out(oe_n), .weak_pullup_enable_out(pu), .weak_pulldown_enable_out(pd),
		.analog_select_out(an), .periph_enable_in(pen_b), .periph_drive_in(pdrv),
		.periph_out_in(pout), .periph_od_in('0), .periph_pin_level_out(plev),
		.change_irq_out(irq));
	pio_pad_model u_pad (.drv_in(pout_o), .oe_n_in(oe_n), .ext_in(ext), .pad_out(pad));
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction
	function automatic logic [ADDR_W-1:0] ra(input int pp, input logic [2:0] k);
		return ADDR_W'((pp << PORT_LSB) | (int'(k) << REG_LSB));
	endfunction
	// Upper half: expected oe_n, lower half: driven value
	function automatic logic [31:0] exp_pin(input logic [15:0] ow, pv, d, lt, od);
		return {~ow & (d | (od & lt)), (ow & pv) | (~ow & lt)};
	endfunction
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		rdata = prd;
		rerr = err;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 20) fail_count++;
		@(posedge clk);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		xfer(1'b1, a, {16'h0000, d});
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e, input string s);
		xfer(1'b0, a, '0);
		`CHK(rdata, {16'h0000, e}, s)
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK(oe_n, {W{1'b1}}, "oe reset")
		for (int i = 0; i < NUM_PORTS; i++) begin
			rd_chk(ra(i, IDX_DIRECTION), DIRECTION_RESET & PIN_IMPL[i*16 +: 16], "dir rst");
			rd_chk(ra(i, IDX_ANALOG_SELECT), ANALOG_RESET & ANALOG_IMPL[i*16 +: 16], "an rst");
			wr(ra(i, IDX_ANALOG_SELECT), 16'h0000);
		end
		$display("test reset done");
		for (int i = 0; i < 30; i++) begin
			p = i % NUM_PORTS;
			l = rnd();
			t = rnd();
			o = rnd();
			en = rnd();
			dv = rnd();
			v = rnd();
			m = PIN_IMPL[p*16 +: 16];
			pen_b[p*16 +: 16] <= en;
			pdrv[p*16 +: 16] <= dv;
			pout[p*16 +: 16] <= v;
			wr(ra(p, i[0] ? IDX_PIN_LEVEL : IDX_OUTPUT_LATCH), l);
			wr(ra(p, IDX_DIRECTION), t);
			wr(ra(p, IDX_OPEN_DRAIN), o);
			wr(ra(p, IDX_PULLUP_ENABLE), l ^ t);
			wr(ra(p, IDX_PULLDOWN_ENABLE), o);
			q = exp_pin(en & dv, v, t, l, o);
			@(posedge clk);
			`CHK(oe_n[p*16 +: 16] & m, q[31:16] & m, "oe")
			`CHK(pout_o[p*16 +: 16] & ~q[31:16] & m, q[15:0] & ~q[31:16] & m, "out")
			`CHK(pu[p*16 +: 16], (l ^ t) & m, "pu")
			`CHK(pd[p*16 +: 16], o & m, "pd")
			rd_chk(ra(p, IDX_OUTPUT_LATCH), l & m, "lat");
			rd_chk(ra(p, IDX_DIRECTION), t & m, "dir");
		end
		$display("test random pins done");
		pen_b <= '0;
		ext <= {rnd(), rnd(), rnd(), rnd(), rnd()};
		wr(ra(1, IDX_DIRECTION), 16'hFFFF);
		repeat (2) @(posedge clk);
		rd_chk(ra(1, IDX_PIN_LEVEL), ext[31:16] & PIN_IMPL[31:16], "level");
		wr(ra(1, IDX_ANALOG_SELECT), 16'hFFFF);
		rd_chk(ra(1, IDX_PIN_LEVEL), ext[31:16] & PIN_IMPL[31:16] & ~ANALOG_IMPL[31:16], "an");
		wr(ra(1, IDX_ANALOG_SELECT), 16'h0000);
		xfer(1'b0, 12'h200, '0);
		`CHK({rerr, rdata}, {1'b1, ZERO_DATA}, "unmapped")
		$display("test level done");
		wr(ra(1, IDX_CHANGE_IRQ_ENABLE), 16'h0001);
		wr(ADDR_CHANGE_MASK, 16'h0002);
		xfer(1'b0, ADDR_CHANGE_STATUS_PORT + 12'h010, '0);
		ext[17:16] <= ~ext[17:16];
		repeat (5) @(posedge clk);
		`CHK(irq, 1'b0, "masked irq")
		wr(ADDR_CHANGE_MASK_PORT + 12'h010, 16'h0001);
		@(posedge clk);
		`CHK(irq, 1'b1, "irq")
		rd_chk(ADDR_CHANGE_STATUS_PORT + 12'h010, 16'h0001, "flag");
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0, "irq clear")
		$display("test irq done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK(oe_n, {W{1'b1}}, "oe reset 2")
		$display("test reset again done");
		wrap_up();
	end
endmodule
